/* verilog/bda_exec_unit.sv */
// Execution unit for decimal adjust, decrement, divide and loop branch
// Notes on behaviour
// (RL1) Decimal adjust adds six when low nibble exceeds nine or aux carry set
// (RL2) A carry from the low correction sets carry, never clears it
// (RL3) Then add six to high nibble if carry set or high nibble above nine
// (RL4) High correction carry sets carry; overflow flag stays as it was
// (RL5) Decimal adjust is one opcode byte and finishes in one cycle
// (RL6) Decrement subtracts one, zero wraps to all ones, flags untouched
// (RL7) Read-modify-write of a port takes its output latch, not the pins
// (RL8) Decrement forms: accumulator, bank register, direct byte, indirect byte
// (RL9) Divide puts quotient in accumulator, remainder in B, clears carry, ovf
// (RL10) Zero divisor sets overflow and clears carry; results undefined
// (RL11) Divide is a one-byte unsigned opcode taking four cycles
// (RL12) Loop branch decrements, branches only on nonzero, leaves flags alone
// (RL13) Branch target is next instruction address plus sign-extended last byte
// (RL14) Loop branch operand is only a bank register or a direct byte
// (RL15) Loop branch takes two cycles whether taken or not
// (RL16) Loop branch: register form two bytes, direct form three bytes
// (RL17) Bank registers and pointers resolve within the selected bank
`timescale 1ns/1ns
module bda_exec_unit
  import bda_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire bda_issue_t  issue,
  output logic             issueReady,
  input  wire logic [7:0]  memRdData,
  output bda_mem_t         mem,
  output bda_result_t      result
);

  bda_ctx_t s_q;
  bda_ctx_t s_d;

  // Register-file address of bank register idx in the selected bank
  function automatic logic [7:0] bankAddr(input logic [7:0] program_status_word,
                                          input logic [2:0] idx);
    bankAddr = {3'h0, program_status_word[PSW_RS1], program_status_word[PSW_RS0], idx};
  endfunction

  // Opcode with its register or pointer select field cleared, so one
  // plain case can decode every form
  function automatic logic [7:0] opBase(input logic [7:0] opc);
    if (opc[7:3] == OPC_DEC_REG[7:3] || opc[7:3] == OPC_DECREMENT_BRANCH_NONZERO_OP_REG[7:3])
      opBase = {opc[7:3], 3'h0};
    else if (opc[7:1] == OPC_DEC_IND[7:1])
      opBase = {opc[7:1], 1'b0};
    else
      opBase = opc;
  endfunction

  // One restoring division step: {remainder, dividend/quotient}
  function automatic logic [15:0] divBit(input logic [15:0] rq,
                                         input logic [7:0]  d);
    logic [8:0] t;
    logic [8:0] r;
    t = {rq[15:8], rq[7]};
    r = t - {1'b0, d};
    if (t >= {1'b0, d})
      divBit = {r[7:0], rq[6:0], 1'b1};
    else
      divBit = {t[7:0], rq[6:0], 1'b0};
  endfunction

  assign issueReady = s_q.ready;
  assign mem        = s_q.mem;
  assign result     = s_q.res;

  // Next-state logic; all strobes default low so they last one cycle
  always_comb
  begin
    logic [8:0]  daLo;
    logic [8:0]  daHi;
    logic        daCy;
    logic [15:0] pcNext;
    logic [15:0] rqNext;
    logic [7:0]  opKey;
    daLo   = '0;
    daHi   = '0;
    daCy   = 1'b0;
    pcNext = '0;
    rqNext = '0;
    opKey  = opBase(issue.opcode);
    s_d = s_q;
    s_d.res.done  = 1'b0;
    s_d.res.accWe = 1'b0;
    s_d.res.bWe   = 1'b0;
    s_d.res.pswWe = 1'b0;
    s_d.res.pcWe  = 1'b0;
    s_d.mem.we    = 1'b0;

    // Both nibble corrections are one chained adder path
    daCy = issue.program_status_word[PSW_CY];
    daLo = {1'b0, issue.acc};
    if (issue.acc[3:0] > BCD_MAX || issue.program_status_word[PSW_AC])
      daLo = daLo + BCD_FIX_LO; // RL1
    daCy = daCy | daLo[8]; // RL2
    daHi = {1'b0, daLo[7:0]};
    if (daCy || daLo[7:4] > BCD_MAX)
      daHi = daHi + BCD_FIX_HI; // RL3
    daCy = daCy | daHi[8]; // RL4

    case (s_q.st)
      ST_IDLE:
      begin
        s_d.ready = 1'b1;
        if (issue.valid)
        begin
          s_d.pc   = issue.pc;
          s_d.acc  = issue.acc;
          s_d.bReg = issue.bReg;
          s_d.program_status_word  = issue.program_status_word;
          case (opKey)
            OPC_DA:
            begin
              // Single cycle, so back-to-back issue stays possible
              s_d.kind       = K_DA; // RL5
              s_d.res.acc    = daHi[7:0];
              s_d.res.accWe  = 1'b1;
              s_d.res.program_status_word    = issue.program_status_word;
              s_d.res.program_status_word[PSW_CY] = daCy; // RL4
              s_d.res.pswWe  = 1'b1;
              s_d.res.done   = 1'b1;
            end
            OPC_DEC_A:
            begin
              s_d.kind      = K_DECA;
              s_d.res.acc   = issue.acc - DEC_ONE; // RL6 RL8
              s_d.res.accWe = 1'b1;
              s_d.res.done  = 1'b1;
            end
            OPC_DEC_DIR, OPC_DECREMENT_BRANCH_NONZERO_OP_DIR:
            begin
              // Port output latch is used for the read-modify-write
              s_d.kind        = (issue.opcode == OPC_DEC_DIR) ?
                                K_DECM : K_DECREMENT_BRANCH_NONZERO_OP;
              s_d.djDir       = 1'b1;
              s_d.rel         = issue.byte2; // RL16
              s_d.mem.rdAddr  = issue.byte1; // RL8 RL14
              s_d.mem.rdLatch = 1'b1; // RL7
              s_d.ready       = 1'b0;
              s_d.st          = ST_OPND;
            end
            OPC_DEC_IND:
            begin
              s_d.kind        = K_DECM;
              s_d.mem.rdAddr  = bankAddr(issue.program_status_word,
                                         {2'h0, issue.opcode[0]}); // RL17
              s_d.mem.rdLatch = 1'b0;
              s_d.ready       = 1'b0;
              s_d.st          = ST_PTR; // RL8
            end
            OPC_DEC_REG, OPC_DECREMENT_BRANCH_NONZERO_OP_REG:
            begin
              s_d.kind        = (opKey == OPC_DEC_REG) ?
                                K_DECM : K_DECREMENT_BRANCH_NONZERO_OP;
              s_d.djDir       = 1'b0;
              s_d.rel         = issue.byte1; // RL16
              s_d.mem.rdAddr  = bankAddr(issue.program_status_word,
                                         issue.opcode[2:0]); // RL17 RL14
              s_d.mem.rdLatch = 1'b0;
              s_d.ready       = 1'b0;
              s_d.st          = ST_OPND;
            end
            OPC_DIV:
            begin
              // First two quotient bits form in the take cycle, so the
              // whole divide fits the four-cycle budget
              s_d.kind   = K_DIV;
              s_d.rq     = divBit(divBit({8'h00, issue.acc}, issue.bReg),
                                  issue.bReg);
              s_d.divCnt = DIV_CYCLES - 3'h1; // RL11
              s_d.ready  = 1'b0;
              s_d.st     = ST_DIV;
            end
            default:
            begin
              // Opcodes outside this unit are dropped silently
              s_d.kind = K_NONE;
            end
          endcase
        end
      end
      ST_PTR:
      begin
        // Pointer byte now on the read port; fetch the target byte
        s_d.mem.rdAddr  = memRdData; // RL17
        s_d.mem.rdLatch = 1'b0;
        s_d.st          = ST_OPND;
      end
      ST_OPND:
      begin
        // Write-back, loop decision and target all land in this cycle
        s_d.decVal     = memRdData - DEC_ONE; // RL6 RL12
        s_d.mem.we     = 1'b1;
        s_d.mem.wrAddr = s_q.mem.rdAddr;
        s_d.mem.wrData = s_d.decVal;
        s_d.res.done   = 1'b1;
        s_d.ready      = 1'b1;
        s_d.st         = ST_IDLE; // RL15
        if (s_q.kind == K_DECREMENT_BRANCH_NONZERO_OP)
        begin
          // Status word is never written, so no flag can move
          pcNext = s_q.pc + (s_q.djDir ? LEN_DJ_DIR : LEN_DJ_REG); // RL16
          s_d.res.taken = (s_d.decVal != 8'h00); // RL12
          s_d.res.pc    = s_d.res.taken ?
                          pcNext + {{8{s_q.rel[7]}}, s_q.rel} :
                          pcNext; // RL13
          s_d.res.pcWe  = 1'b1;
        end
      end
      ST_DIV:
      begin
        // Two quotient bits per cycle gives eight bits in four cycles
        rqNext     = divBit(divBit(s_q.rq, s_q.bReg), s_q.bReg);
        s_d.rq     = rqNext;
        s_d.divCnt = s_q.divCnt - 3'h1;
        if (s_q.divCnt == 3'h1)
        begin
          s_d.res.acc   = rqNext[7:0]; // RL9
          s_d.res.bReg  = rqNext[15:8];
          s_d.res.accWe = 1'b1;
          s_d.res.bWe   = 1'b1;
          s_d.res.program_status_word   = s_q.program_status_word;
          s_d.res.program_status_word[PSW_CY] = 1'b0; // RL9 RL10
          s_d.res.program_status_word[PSW_OV] = (s_q.bReg == 8'h00); // RL10
          s_d.res.pswWe = 1'b1;
          s_d.res.done  = 1'b1;
          s_d.ready     = 1'b1;
          s_d.st        = ST_IDLE; // RL11
        end
      end
      default:
      begin
        s_d.ready = 1'b1;
        s_d.st    = ST_IDLE;
      end
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk)
  begin
    if (srst)
      s_q <= CTX_RESET;
    else if (ce)
      s_q <= s_d;
  end

  wire acceptNow = ce && s_q.ready && issue.valid;

  sequence sDivIssue;
    acceptNow && issue.opcode == OPC_DIV;
  endsequence

  sequence sDjIssue;
    acceptNow && (opBase(issue.opcode) == OPC_DECREMENT_BRANCH_NONZERO_OP_DIR ||
                  opBase(issue.opcode) == OPC_DECREMENT_BRANCH_NONZERO_OP_REG);
  endsequence

  // Cycle-count checks only count cycles with ce high, as the counts assume it
  a_da_one_cycle: assert property (@(posedge clk) disable iff (srst) // RL5
    (acceptNow && issue.opcode == OPC_DA) |=> result.done && result.accWe)
    else $error("decimal adjust did not finish in one cycle");

  a_da_carry_kept: assert property (@(posedge clk) disable iff (srst) // RL2
    (result.done && s_q.kind == K_DA && s_q.program_status_word[PSW_CY])
      |-> result.program_status_word[PSW_CY])
    else $error("decimal adjust cleared the carry");

  a_da_ov_kept: assert property (@(posedge clk) disable iff (srst) // RL4
    (result.done && s_q.kind == K_DA)
      |-> result.program_status_word[PSW_OV] == s_q.program_status_word[PSW_OV])
    else $error("decimal adjust changed overflow");

  a_div_four_cycles: assert property (@(posedge clk) disable iff (srst) // RL11
    sDivIssue ##1 ce[*3] |=> result.done && result.bWe)
    else $error("divide did not take four cycles");

  a_div_busy: assert property (@(posedge clk) disable iff (srst) // RL11
    sDivIssue |=> !issueReady)
    else $error("unit stayed ready during divide");

  a_div_result: assert property (@(posedge clk) disable iff (srst) // RL9
    (result.done && s_q.kind == K_DIV && s_q.bReg != 8'h00)
      |-> result.acc == s_q.acc / s_q.bReg &&
          result.bReg == s_q.acc % s_q.bReg && !result.program_status_word[PSW_OV])
    else $error("divide quotient or remainder wrong");

  a_div_zero: assert property (@(posedge clk) disable iff (srst) // RL10
    (result.done && s_q.kind == K_DIV && s_q.bReg == 8'h00)
      |-> result.program_status_word[PSW_OV] && !result.program_status_word[PSW_CY])
    else $error("zero divisor flags wrong");

  a_dec_wrap: assert property (@(posedge clk) disable iff (srst) // RL6
    (mem.we && $past(ce)) |-> mem.wrData == $past(memRdData) - DEC_ONE)
    else $error("decrement result wrong");

  a_dj_two_cycles: assert property (@(posedge clk) disable iff (srst) // RL15
    sDjIssue ##1 ce |=> result.done && result.pcWe)
    else $error("loop branch cycle count wrong");

  a_dj_taken: assert property (@(posedge clk) disable iff (srst) // RL12
    result.pcWe |-> mem.we && !result.pswWe &&
                    result.taken == (mem.wrData != 8'h00))
    else $error("loop branch decision or flags wrong");

  a_dec_no_flags: assert property (@(posedge clk) disable iff (srst) // RL6
    mem.we |-> !result.pswWe)
    else $error("decrement wrote the status word");

  a_latch_read: assert property (@(posedge clk) disable iff (srst) // RL7
    (acceptNow && (issue.opcode == OPC_DEC_DIR ||
                   issue.opcode == OPC_DECREMENT_BRANCH_NONZERO_OP_DIR)) |=> mem.rdLatch)
    else $error("port read did not use output latch");

endmodule

/* verilog/bda_pkg.sv */
// Shared constants, opcodes and carrier types of the adjust/divide datapath
package bda_pkg;

  // Status word bit positions
  localparam int PSW_CY  = 7;
  localparam int PSW_AC  = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV  = 2;

  // Opcodes; forms with a register or pointer select field carry it as zero
  localparam logic [7:0] OPC_DA       = 8'hd4;
  localparam logic [7:0] OPC_DEC_A    = 8'h14;
  localparam logic [7:0] OPC_DEC_DIR  = 8'h15;
  localparam logic [7:0] OPC_DEC_IND  = 8'h16;
  localparam logic [7:0] OPC_DEC_REG  = 8'h18;
  localparam logic [7:0] OPC_DIV      = 8'h84;
  localparam logic [7:0] OPC_DECREMENT_BRANCH_NONZERO_OP_DIR = 8'hd5;
  localparam logic [7:0] OPC_DECREMENT_BRANCH_NONZERO_OP_REG = 8'hd8;

  // Decimal correction constants
  localparam logic [3:0] BCD_MAX    = 4'h9;
  localparam logic [8:0] BCD_FIX_LO = 9'h006;
  localparam logic [8:0] BCD_FIX_HI = 9'h060;

  // Timing and instruction lengths
  localparam logic [2:0]  DIV_CYCLES = 3'h4;
  localparam logic [15:0] LEN_DJ_REG = 16'h0002;
  localparam logic [15:0] LEN_DJ_DIR = 16'h0003;
  localparam logic [7:0]  DEC_ONE    = 8'h01;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PTR  = 5'h02,
    ST_OPND = 5'h04,
    ST_BRCH = 5'h08,
    ST_DIV  = 5'h10
  } bda_state_t;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_DA   = 3'h1,
    K_DECA = 3'h2,
    K_DECM = 3'h3,
    K_DIV  = 3'h4,
    K_DECREMENT_BRANCH_NONZERO_OP = 3'h5
  } bda_kind_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  bReg;
    logic [7:0]  program_status_word;
  } bda_issue_t;

  typedef struct packed {
    logic [7:0] rdAddr;
    logic       rdLatch;
    logic       we;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
  } bda_mem_t;

  typedef struct packed {
    logic        done;
    logic        accWe;
    logic [7:0]  acc;
    logic        bWe;
    logic [7:0]  bReg;
    logic        pswWe;
    logic [7:0]  program_status_word;
    logic        pcWe;
    logic [15:0] pc;
    logic        taken;
  } bda_result_t;

  typedef struct packed {
    bda_state_t  st;
    bda_kind_t   kind;
    logic        ready;
    logic        djDir;
    logic [7:0]  rel;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  bReg;
    logic [7:0]  program_status_word;
    logic [15:0] rq;
    logic [2:0]  divCnt;
    logic [7:0]  decVal;
    bda_mem_t    mem;
    bda_result_t res;
  } bda_ctx_t;

  localparam bda_ctx_t CTX_RESET = '{st: ST_IDLE, kind: K_NONE,
                                     ready: 1'b1, default: '0};

endpackage

/* tb/bda_exec_unit_tb_top.sv */
// Self-checking bench for the adjust, decrement, divide and loop unit
`timescale 1ns/1ns
module bda_exec_unit_tb_top;
  import bda_pkg::*;

  logic        clk;
  logic        srst;
  logic        ce;
  bda_issue_t  issue;
  logic        issueReady;
  logic [7:0]  memRdData;
  bda_mem_t    mem;
  bda_result_t result;
  logic [7:0]  ram [256];
  int          num_errors;
  int          compares;
  int          cycles;
  int          lat;
  logic [7:0]  firstAddr;
  logic        firstLatch;
  logic        firstReady;

  bda_exec_unit uut
  (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .issue      (issue),
    .issueReady (issueReady),
    .memRdData  (memRdData),
    .mem        (mem),
    .result     (result)
  );

  // Clock of 8 ns period
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Memory answers in the same cycle; bench never writes back, so each
  // scenario seeds the bytes it needs
  assign memRdData = ram[mem.rdAddr];

  // Hang guard; the whole run needs under a hundred cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  // Compare one value and count the outcome
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Issue one instruction, count edges from the take edge until done or eight edges
  task automatic run(input logic [7:0] opc, b1, b2, a, b, program_status_word);
    @(posedge clk);
    issue <= '{valid: 1'b1, opcode: opc, byte1: b1, byte2: b2,
               pc: 16'h1000, acc: a, bReg: b, program_status_word: program_status_word};
    lat = 0;
    do
    begin
      @(posedge clk);
      issue.valid <= 1'b0;
      lat++;
      #1;
      if (lat == 1)
      begin
        firstAddr = mem.rdAddr;
        firstLatch = mem.rdLatch;
        firstReady = issueReady;
      end
    end while (result.done !== 1'b1 && lat < 8);
  endtask

  // Decimal adjust: acc in, psw in, acc out, psw out
  task automatic t_da();
    logic [31:0] tab [5] = '{32'hbe00_2480, 32'hc900_2980,
                             32'h1140_1740, 32'h9a00_0080,
                             32'h4584_a584};
    foreach (tab[i])
    begin
      run(OPC_DA, 8'h00, 8'h00, tab[i][31:24], 8'h00, tab[i][23:16]);
      chk("da cycles", 16'(lat), 16'h0001);
      chk("da acc", result.acc, tab[i][15:8]);
      chk("da psw", result.program_status_word, tab[i][7:0]);
      chk("da strobes", {result.accWe, result.pswWe}, 2'h3);
    end
  endtask

  // Divide, normal and zero divisor
  task automatic t_div();
    run(OPC_DIV, 8'h00, 8'h00, 8'hfb, 8'h12, 8'hff);
    chk("div cycles", 16'(lat), 16'h0004);
    chk("div acc", result.acc, 8'h0d);
    chk("div b", result.bReg, 8'h11);
    chk("div bwe", result.bWe, 1'b1);
    chk("div psw", result.program_status_word, 8'h7b);
    chk("div ready", {firstReady, issueReady}, 2'h1);
    run(OPC_DIV, 8'h00, 8'h00, 8'h55, 8'h00, 8'h80);
    chk("div0 cycles", 16'(lat), 16'h0004);
    chk("div0 psw", result.program_status_word, 8'h04);
  endtask

  // Decrement of the accumulator wraps zero
  task automatic t_dec_a();
    run(OPC_DEC_A, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff);
    chk("deca cycles", 16'(lat), 16'h0001);
    chk("deca acc", result.acc, 8'hff);
    chk("deca pswwe", result.pswWe, 1'b0);
  endtask

  // Decrement of direct, bank register and indirect bytes
  task automatic t_dec_mem();
    ram[8'h90] = 8'ha5;
    run(8'h15, 8'h90, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("decd cycles", 16'(lat), 16'h0002);
    chk("decd addr", firstAddr, 8'h90);
    chk("decd latch", firstLatch, 1'b1);
    chk("decd data", mem.wrData, 8'ha4);
    chk("decd we", mem.we, 1'b1);
    chk("decd pswwe", result.pswWe, 1'b0);
    ram[8'h15] = 8'h00;
    run(8'h1d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10);
    chk("decr addr", firstAddr, 8'h15);
    chk("decr data", {mem.wrAddr, mem.wrData}, 16'h15ff);
    ram[8'h09] = 8'h7f;
    ram[8'h7f] = 8'h40;
    run(8'h17, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08);
    chk("deci cycles", 16'(lat), 16'h0003);
    chk("deci ptr", firstAddr, 8'h09);
    chk("deci latch", firstLatch, 1'b0);
    chk("deci data", {mem.wrAddr, mem.wrData}, 16'h7f3f);
  endtask

  // Loop branch, taken backwards on a register, not taken on direct
  task automatic t_decrement_branch_nonzero_op();
    ram[8'h1b] = 8'h05;
    run(8'hdb, 8'hfc, 8'h00, 8'h00, 8'h00, 8'h18);
    chk("djr cycles", 16'(lat), 16'h0002);
    chk("djr pcwe", result.pcWe, 1'b1);
    chk("djr addr", firstAddr, 8'h1b);
    chk("djr data", mem.wrData, 8'h04);
    chk("djr taken", result.taken, 1'b1);
    chk("djr pc", result.pc, 16'h0ffe);
    chk("djr pswwe", result.pswWe, 1'b0);
    ram[8'h40] = 8'h01;
    run(OPC_DECREMENT_BRANCH_NONZERO_OP_DIR, 8'h40, 8'h10, 8'h00, 8'h00, 8'h00);
    chk("djd cycles", 16'(lat), 16'h0002);
    chk("djd latch", firstLatch, 1'b1);
    chk("djd data", mem.wrData, 8'h00);
    chk("djd taken", result.taken, 1'b0);
    chk("djd pc", result.pc, 16'h1003);
  endtask

  // An opcode outside the set gets no answer
  task automatic t_refuse();
    run(8'hd6, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    chk("refused done", result.done, 1'b0);
    chk("refused ready", issueReady, 1'b1);
  endtask

  // Clock enable low freezes the unit; the held request is taken later
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    issue <= '{valid: 1'b1, opcode: OPC_DEC_A, byte1: 8'h00, byte2: 8'h00,
               pc: 16'h1000, acc: 8'h08, bReg: 8'h00, program_status_word: 8'h00};
    repeat (3) @(posedge clk);
    #1;
    chk("frozen done", {result.done, issueReady}, 16'h0001);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    issue.valid <= 1'b0;
    #1;
    chk("thawed acc", {result.done, result.acc}, 16'h0107);
  endtask

  // Print counts and verdict, then stop
  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Reset for 16 cycles, then run every scenario
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    issue = '0;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    foreach (ram[i]) ram[i] = 8'(i) ^ 8'h5a;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_da();
    t_div();
    t_dec_a();
    t_dec_mem();
    t_decrement_branch_nonzero_op();
    t_refuse();
    t_freeze();
    complete_run();
  end
endmodule
